// *** egc_map.svh ***
// Offsets, field positions, reset values and timing figures of the global control bank
`ifndef EGC_MAP_SVH
`define EGC_MAP_SVH
// Register indices on the register port
`define EGC_CTL2_IDX 1'b0
`define EGC_LEDID_IDX 1'b1
// Power-on values
`define EGC_CTL2_POR 16'hCB00
`define EGC_CODIV_POR 4'hB
`define EGC_LEDCFG_POR 8'h26
// global_control_two fields
`define EGC_ENABLE_BIT 15
`define EGC_STRETCH_BIT 14
`define EGC_SAINS_BIT 13
`define EGC_HASH_BIT 12
`define EGC_CODIV_HI 11
`define EGC_CODIV_LO 8
`define EGC_AUTO_PAUSE_ENABLE_BIT 7
`define EGC_TRANSMIT_RESET_BIT_BIT 6
`define EGC_RECEIVE_RESET_BIT_BIT 5
`define EGC_MRST_BIT 4
`define EGC_MODEXP_LENGTH_SELECT_HI 3
`define EGC_MODEXP_LENGTH_SELECT_LO 2
`define EGC_CIPHER_KEY_LENGTH_SELECT_HI 1
`define EGC_CIPHER_KEY_LENGTH_SELECT_LO 0
// led_config_and_id fields
`define EGC_LED_OUTPUT_ONE_HI 15
`define EGC_LED_OUTPUT_ONE_LO 12
`define EGC_LED_OUTPUT_TWO_HI 11
`define EGC_LED_OUTPUT_TWO_LO 8
`define EGC_DEVICE_IDENTIFIER_HI 7
`define EGC_DEVICE_IDENTIFIER_LO 5
`define EGC_SILICON_REVISION_HI 4
`define EGC_SILICON_REVISION_LO 0
// Timing
`define EGC_CLK_HZ 25000000
`define EGC_MRST_US 25
`define EGC_STRETCH_MS 50
`endif

// *** egc_pkg.sv ***
// Types shared by the global control bank
package egc_pkg;
  typedef logic [15:0] egc_word_t;
  typedef logic [3:0] egc_code_t;
  typedef enum logic [1:0] {
    EGC_RUN  = 2'b01,
    EGC_MRST = 2'b10
  } egc_state_t;
endpackage

// *** egc_refclk_div.sv ***
// Reference clock output divider
`timescale 1ns/1ps
module egc_refclk_div (
  input wire logic clk,                 // System clock, used as the divider reference
  input wire logic rst_n,               // Power-on reset only, active low
  input wire egc_pkg::egc_code_t code,  // Divider select code
  output logic ref_out                  // Divided clock output
);
  import egc_pkg::*;

  // Period in half reference cycles; zero means stopped
  function automatic logic [11:0] half_period(input egc_code_t c);
    unique case (c)
      4'hF: half_period = 12'hFA0;
      4'hE: half_period = 12'h7D0;
      4'hC: half_period = 12'h040;
      4'hB: half_period = 12'h032;
      4'hA: half_period = 12'h028;
      4'h9: half_period = 12'h020;
      4'h8: half_period = 12'h019;
      4'h7: half_period = 12'h018;
      4'h6: half_period = 12'h014;
      4'h5: half_period = 12'h010;
      4'h4: half_period = 12'h00C;
      4'h3: half_period = 12'h00A;
      4'h2: half_period = 12'h008;
      4'h1: half_period = 12'h006;
      default: half_period = 12'h000;
    endcase
  endfunction

  logic [11:0] acc_ff;
  logic [11:0] nxt_acc;
  logic out_ff;
  wire [11:0] period = half_period(code);
  wire stopped = (period == 12'h000);
  wire [11:0] sum = acc_ff + 12'h002;
  // Odd half-period (12.5) alternates 12 and 13 cycles, so duty is uneven
  assign nxt_acc = (acc_ff >= period) ? 12'h000 :
                   (sum >= period) ? 12'(sum - period) : sum;

  always_ff @(posedge clk) begin
    if (!rst_n || stopped) begin
      acc_ff <= 12'h000;
      out_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      out_ff <= (nxt_acc < (period >> 1));
    end
  end

  assign ref_out = out_ff;
endmodule

// *** egc_top.sv ***
// Global control, LED drive and identification bank of the Ethernet controller
//
// Functional notes
// - Enable bit high runs device, low powers down
// - Stretch bit lengthens LED events to 50 ms
// - Insert bit enables station source address insertion
// - Hash select: one SHA-1, zero MD5
// - Clock output divides by selected table divisor
// - Codes 1101, 0000 stop output low
// - Divider field resets only at power-on
// - Auto pause bit enables flow control, resets zero
// - Transmit reset holds logic, clears transmit request
// - Receive reset holds logic, clears receive enable
// - Master reset clears all but divider, self-clears
// - Modexp length: 512, 768, 1024, reserved
// - Key length: 128, 192, 256, reserved
// - LED codes 0000 to 1000 show states
// - LED codes 1001 to 1100 show link, blink low
// - Bi-color codes need equal LED fields
// - Identifier register: device id, silicon revision
`timescale 1ns/1ps
`include "egc_map.svh"
module egc_top #(
  parameter int STRETCH_CYCLES = (`EGC_STRETCH_MS * (`EGC_CLK_HZ / 1000)),
  parameter logic [2:0] DEVICE_ID = 3'h5,  // Arbitrary value
  parameter logic [4:0] REVISION = 5'h03   // Arbitrary value
) (
  input wire logic clk,                      // 25 MHz oscillator clock
  input wire logic rst_n,                    // Power-on reset, active low
  input wire logic reg_sel,                  // Register index
  input wire logic reg_wr,                   // Write strobe
  input wire logic reg_rd,                   // Read strobe
  input wire logic [1:0] reg_be,             // Byte enables, bit 1 high byte
  input wire egc_pkg::egc_word_t reg_wdata,  // Write data
  output egc_pkg::egc_word_t reg_rdata,      // Read data
  output logic reg_rvalid,                   // Read data valid pulse
  output logic reg_busy,                     // Port refused during master reset
  input wire logic link_up,                  // PHY link present
  input wire logic speed_100,                // PHY at 100 Mbps
  input wire logic phy_duplex_flag,          // PHY in full duplex
  input wire logic tx_active,                // Frame being transmitted
  input wire logic rx_active,                // Frame being received
  input wire logic collision,                // Collision seen
  output logic device_enable_bit,            // Device enabled
  output logic power_down,                   // Reduced power request
  output logic source_address_insert,        // Station address insertion
  output logic hash_algorithm_select,        // 1 SHA-1, 0 MD5
  output logic auto_pause_enable,            // Automatic flow control
  output logic transmit_reset,               // Hold transmit logic in reset
  output logic receive_reset,                // Hold receive logic in reset
  output logic transmit_request_clear,       // Clear pending transmit request
  output logic receive_enable_clear,         // Clear receive enable
  output logic master_reset,                 // Reset to all other blocks
  output logic [1:0] modexp_length_select,   // Operand size select
  output logic [10:0] modexp_operand_bits,   // Operand size in bits, 0 reserved
  output logic [1:0] cipher_key_length_select, // Key size select
  output logic [8:0] cipher_key_bits,        // Key size in bits, 0 reserved
  output logic led_output_one,               // First LED pin
  output logic led_output_two,               // Second LED pin
  output logic reference_clock_output        // Divided clock output
);
  import egc_pkg::*;

  // ********************************************
  // Constants
  // ********************************************
  localparam int MRST_CYCLES = `EGC_MRST_US * (`EGC_CLK_HZ / 1000000);
  localparam logic [9:0] MRST_LAST = 10'(MRST_CYCLES - 1);
  localparam logic [20:0] STRETCH_LAST = 21'(STRETCH_CYCLES - 1);

  // ********************************************
  // Functions
  // ********************************************
  // Restart on a new event so back-to-back events keep the LED lit
  function automatic logic [20:0] stretch_next(input logic [20:0] cnt, input logic ev);
    if (ev) begin
      stretch_next = STRETCH_LAST;
    end else if (cnt != 21'h000000) begin
      stretch_next = 21'(cnt - 21'h000001);
    end else begin
      stretch_next = 21'h000000;
    end
  endfunction

  // Pin level for one LED; second selects the opposite pin of a bi-color pair
  function automatic logic led_level(
    input egc_code_t code,
    input logic second,
    input logic lnk,
    input logic spd,
    input logic dpx,
    input logic tx,
    input logic rx,
    input logic col
  );
    logic act;
    act = tx | rx;
    unique case (code)
      4'h0: led_level = 1'b0;
      4'h1: led_level = 1'b1;
      4'h2: led_level = lnk;
      4'h3: led_level = col;
      4'h4: led_level = tx;
      4'h5: led_level = rx;
      4'h6: led_level = act;
      4'h7: led_level = dpx & lnk;
      4'h8: led_level = spd & lnk;
      4'h9: led_level = lnk & ~tx;
      4'hA: led_level = lnk & ~rx;
      4'hB: led_level = lnk & ~act;
      4'hC: led_level = lnk & ~col;
      4'hE: led_level = lnk & ~act & (dpx ^ second);
      4'hF: led_level = lnk & ~act & (spd ^ second);
      default: led_level = 1'b0;
    endcase
  endfunction

  // ********************************************
  // State
  // ********************************************
  egc_state_t state_ff;
  egc_state_t nxt_state;
  logic [9:0] mrst_cnt_ff;
  logic [9:0] nxt_mrst_cnt;
  egc_word_t ctl2_ff;
  egc_word_t nxt_ctl2;
  egc_code_t codiv_ff;
  egc_code_t nxt_codiv;
  logic [7:0] ledcfg_ff;
  logic [7:0] nxt_ledcfg;
  egc_word_t rdata_ff;
  logic rvalid_ff;
  logic [20:0] tx_cnt_ff;
  logic [20:0] rx_cnt_ff;
  logic [20:0] col_cnt_ff;
  logic led_one_ff;
  logic led_two_ff;

  // ********************************************
  // Register port decode
  // ********************************************
  wire in_mrst = (state_ff == EGC_MRST);
  wire port_ok = ~in_mrst;
  wire wr_ctl2 = port_ok & reg_wr & (reg_sel == `EGC_CTL2_IDX);
  wire wr_led = port_ok & reg_wr & (reg_sel == `EGC_LEDID_IDX);
  wire wr_ctl2_lo = wr_ctl2 & reg_be[0];
  wire wr_ctl2_hi = wr_ctl2 & reg_be[1];
  wire wr_led_hi = wr_led & reg_be[1];
  wire mrst_go = wr_ctl2_lo & reg_wdata[`EGC_MRST_BIT];
  wire rd_ok = port_ok & reg_rd;

  // ********************************************
  // Master reset sequencer
  // ********************************************
  // Port stays refused while other blocks sit in reset
  always_comb begin
    nxt_state = state_ff;
    nxt_mrst_cnt = mrst_cnt_ff;
    unique case (state_ff)
      EGC_RUN: begin
        if (mrst_go) begin
          nxt_state = EGC_MRST;
          nxt_mrst_cnt = MRST_LAST;
        end
      end
      EGC_MRST: begin
        if (mrst_cnt_ff == 10'h000) begin
          nxt_state = EGC_RUN;
        end else begin
          nxt_mrst_cnt = 10'(mrst_cnt_ff - 10'h001);
        end
      end
      default: begin
        nxt_state = EGC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= EGC_RUN;
      mrst_cnt_ff <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      mrst_cnt_ff <= nxt_mrst_cnt;
    end
  end

  // ********************************************
  // Control registers
  // ********************************************
  // Master reset bit is not stored; it reads back from the sequencer
  always_comb begin
    nxt_ctl2 = ctl2_ff;
    if (wr_ctl2_hi) begin
      nxt_ctl2[15:12] = reg_wdata[15:12];
    end
    if (wr_ctl2_lo) begin
      nxt_ctl2[7:0] = reg_wdata[7:0];
    end
    nxt_ctl2[11:8] = 4'h0;
    nxt_ctl2[`EGC_MRST_BIT] = 1'b0;
    if (mrst_go) begin
      nxt_ctl2 = `EGC_CTL2_POR;
      nxt_ctl2[11:8] = 4'h0;
    end
  end

  // Divider field survives master reset, so a clocked host keeps running
  assign nxt_codiv = wr_ctl2_hi ? reg_wdata[`EGC_CODIV_HI:`EGC_CODIV_LO] : codiv_ff;
  // Identifier bits have no storage, so writes to them do nothing
  assign nxt_ledcfg = mrst_go ? `EGC_LEDCFG_POR :
                      wr_led_hi ? reg_wdata[15:8] : ledcfg_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl2_ff <= `EGC_CTL2_POR;
      ctl2_ff[11:8] <= 4'h0;
      codiv_ff <= `EGC_CODIV_POR;
      ledcfg_ff <= `EGC_LEDCFG_POR;
    end else begin
      ctl2_ff <= nxt_ctl2;
      codiv_ff <= nxt_codiv;
      ledcfg_ff <= nxt_ledcfg;
    end
  end

  // ********************************************
  // Read path
  // ********************************************
  wire [15:0] ctl2_view = {ctl2_ff[15:12], codiv_ff, ctl2_ff[7:5], in_mrst, ctl2_ff[3:0]};
  wire [15:0] ledid_view = {ledcfg_ff, DEVICE_ID, REVISION};
  wire [15:0] rd_mux = (reg_sel == `EGC_CTL2_IDX) ? ctl2_view : ledid_view;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= rd_ok;
      if (rd_ok) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign reg_busy = in_mrst;

  // ********************************************
  // Control outputs
  // ********************************************
  assign device_enable_bit = ctl2_ff[`EGC_ENABLE_BIT];
  assign power_down = ~ctl2_ff[`EGC_ENABLE_BIT];
  assign source_address_insert = ctl2_ff[`EGC_SAINS_BIT];
  assign hash_algorithm_select = ctl2_ff[`EGC_HASH_BIT];
  assign auto_pause_enable = ctl2_ff[`EGC_AUTO_PAUSE_ENABLE_BIT];
  assign master_reset = in_mrst;
  assign transmit_reset = ctl2_ff[`EGC_TRANSMIT_RESET_BIT_BIT] | in_mrst;
  assign receive_reset = ctl2_ff[`EGC_RECEIVE_RESET_BIT_BIT] | in_mrst;
  // Held as a level so a request set during the reset is also refused
  assign transmit_request_clear = ctl2_ff[`EGC_TRANSMIT_RESET_BIT_BIT];
  assign receive_enable_clear = ctl2_ff[`EGC_RECEIVE_RESET_BIT_BIT];
  assign modexp_length_select = ctl2_ff[`EGC_MODEXP_LENGTH_SELECT_HI:`EGC_MODEXP_LENGTH_SELECT_LO];
  assign cipher_key_length_select = ctl2_ff[`EGC_CIPHER_KEY_LENGTH_SELECT_HI:`EGC_CIPHER_KEY_LENGTH_SELECT_LO];

  // Reserved codes report zero so a consumer can refuse to start
  always_comb begin
    unique case (modexp_length_select)
      2'h0: modexp_operand_bits = 11'h200;
      2'h1: modexp_operand_bits = 11'h300;
      2'h2: modexp_operand_bits = 11'h400;
      default: modexp_operand_bits = 11'h000;
    endcase
    unique case (cipher_key_length_select)
      2'h0: cipher_key_bits = 9'h080;
      2'h1: cipher_key_bits = 9'h0C0;
      2'h2: cipher_key_bits = 9'h100;
      default: cipher_key_bits = 9'h000;
    endcase
  end

  // ********************************************
  // LED stretching
  // ********************************************
  wire stretch_on = ctl2_ff[`EGC_STRETCH_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n || in_mrst) begin
      tx_cnt_ff <= 21'h000000;
      rx_cnt_ff <= 21'h000000;
      col_cnt_ff <= 21'h000000;
    end else begin
      tx_cnt_ff <= stretch_next(tx_cnt_ff, tx_active);
      rx_cnt_ff <= stretch_next(rx_cnt_ff, rx_active);
      col_cnt_ff <= stretch_next(col_cnt_ff, collision);
    end
  end

  wire tx_seen = tx_active | (stretch_on & (tx_cnt_ff != 21'h000000));
  wire rx_seen = rx_active | (stretch_on & (rx_cnt_ff != 21'h000000));
  wire col_seen = collision | (stretch_on & (col_cnt_ff != 21'h000000));

  // ********************************************
  // LED drive
  // ********************************************
  wire [3:0] led_one_code = ledcfg_ff[`EGC_LED_OUTPUT_ONE_HI - 8:`EGC_LED_OUTPUT_ONE_LO - 8];
  wire [3:0] led_two_code = ledcfg_ff[`EGC_LED_OUTPUT_TWO_HI - 8:`EGC_LED_OUTPUT_TWO_LO - 8];
  wire led_one_lvl = led_level(led_one_code, 1'b0, link_up, speed_100, phy_duplex_flag,
                               tx_seen, rx_seen, col_seen);
  wire led_two_lvl = led_level(led_two_code, 1'b1, link_up, speed_100, phy_duplex_flag,
                               tx_seen, rx_seen, col_seen);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      led_one_ff <= 1'b0;
      led_two_ff <= 1'b0;
    end else begin
      led_one_ff <= led_one_lvl;
      led_two_ff <= led_two_lvl;
    end
  end

  assign led_output_one = led_one_ff;
  assign led_output_two = led_two_ff;

  // ********************************************
  // Reference clock output
  // ********************************************
  egc_refclk_div u_refclk_div (
    .clk(clk),
    .rst_n(rst_n),
    .code(codiv_ff),
    .ref_out(reference_clock_output)
  );

endmodule

// *** egc_monitor.sv ***
// Port-level assertions for the global control bank
`timescale 1ns/1ps
module egc_monitor (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic reg_sel, // Index
  input wire logic reg_wr, // Write
  input wire logic [1:0] reg_be, // Lanes
  input wire egc_pkg::egc_word_t reg_wdata, // Data
  input wire logic reg_busy, // Busy
  input wire logic device_enable_bit, // Enable
  input wire logic power_down, // Low power
  input wire logic source_address_insert, // Insert
  input wire logic hash_algorithm_select, // Hash
  input wire logic transmit_reset, // Tx reset
  input wire logic receive_reset, // Rx reset
  input wire logic transmit_request_clear, // Tx clear
  input wire logic receive_enable_clear, // Rx clear
  input wire logic master_reset, // Master reset
  input wire logic [1:0] modexp_length_select, // Operand code
  input wire logic [10:0] modexp_operand_bits, // Operand size
  input wire logic [1:0] cipher_key_length_select, // Key code
  input wire logic [8:0] cipher_key_bits, // Key size
  input wire logic reference_clock_output // Divided clock
);
  import egc_pkg::*;
  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_ctl;
  // Accepted writes only: the port ignores everything while busy
  assign wr_ctl = reg_wr && !reg_busy && !reg_sel;
  a_enable_inverse: assert property (power_down != device_enable_bit)
    else $error("power_down equals enable");
  a_upper_write: assert property (wr_ctl && reg_be == 2'b10 |=>
    {device_enable_bit, source_address_insert, hash_algorithm_select} == {$past(reg_wdata[15]), $past(reg_wdata[13:12])})
    else $error("upper control bits not stored");
  a_tx_reset: assert property (wr_ctl && reg_be[0] && reg_wdata[6] && !reg_wdata[4] |=>
    transmit_reset && transmit_request_clear) else $error("transmit reset not applied");
  a_rx_reset: assert property (wr_ctl && reg_be[0] && reg_wdata[5] && !reg_wdata[4] |=>
    receive_reset && receive_enable_clear) else $error("receive reset not applied");
  a_mrst_start: assert property (wr_ctl && reg_be[0] && reg_wdata[4] |=> master_reset && reg_busy)
    else $error("master reset not started");
  a_mrst_length: assert property ($rose(master_reset) |-> ##[624:624] master_reset ##1 !master_reset)
    else $error("master reset length wrong");
  a_refclk_stop: assert property (wr_ctl && reg_be[1] && (reg_wdata[11:8] == 4'h0 || reg_wdata[11:8] == 4'hD)
    |-> ##2 !reference_clock_output [*6]) else $error("clock output not stopped");
  a_modexp_size: assert property (modexp_operand_bits ==
    ((modexp_length_select == 2'b11) ? 11'h000 : 11'h200 + {modexp_length_select, 8'h00}))
    else $error("operand size wrong");
  a_key_size: assert property (cipher_key_bits ==
    ((cipher_key_length_select == 2'b11) ? 9'h000 : 9'h080 + {cipher_key_length_select, 6'h00}))
    else $error("key size wrong");
endmodule
bind egc_top egc_monitor u_egc_monitor (.clk, .rst_n, .reg_sel, .reg_wr, .reg_be, .reg_wdata, .reg_busy,
  .device_enable_bit, .power_down, .source_address_insert, .hash_algorithm_select, .transmit_reset,
  .receive_reset, .transmit_request_clear, .receive_enable_clear, .master_reset, .modexp_length_select,
  .modexp_operand_bits, .cipher_key_length_select, .cipher_key_bits, .reference_clock_output);

// *** egc_host_model.sv ***
// Host controller model driving the register port
`timescale 1ns/1ps
module egc_host_model #(
  parameter int MRST_WAIT = 625 // 25 us at 25 MHz
) (
  input wire logic clk, // Clock
  input wire egc_pkg::egc_word_t reg_rdata, // Read data
  input wire logic reg_rvalid, // Read valid
  output logic reg_sel, // Index
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [1:0] reg_be, // Lanes
  output egc_pkg::egc_word_t reg_wdata // Write data
);
  import egc_pkg::*;
  // ****************
  // Port tasks
  // ****************
  initial begin
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 2'b00;
    reg_wdata = 16'h0000;
  end
  // Released lines show the inverse so stale data never looks valid
  task automatic wr_raw(input logic sel, input logic [1:0] be, input egc_word_t d);
    @(negedge clk);
    reg_sel = sel;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_be = ~be;
    reg_wdata = ~d;
  endtask
  task automatic wr(input logic sel, input logic [1:0] be, input egc_word_t d);
    wr_raw(sel, be, d);
    if (!sel && be[0] && d[4]) begin
      repeat (MRST_WAIT) @(negedge clk);
    end
  endtask
  // Post-link setup kept by the host; the gap and duplex registers sit outside this bank
  logic mac_full_duplex_bit;
  logic [6:0] nonconsecutive_gap_low_byte;
  logic [6:0] consecutive_gap_register;
  task automatic link_setup(input logic phy_duplex_flag, input int gap_nibbles);
    nonconsecutive_gap_low_byte = 7'h12;
    mac_full_duplex_bit = phy_duplex_flag;
    consecutive_gap_register = phy_duplex_flag ? 7'(gap_nibbles - 3) : 7'(gap_nibbles - 6);
  endtask
  task automatic rd(input logic sel, output egc_word_t q, output logic ok);
    @(negedge clk);
    reg_sel = sel;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_sel = ~sel;
    q = reg_rdata;
    ok = reg_rvalid;
  endtask
endmodule

// *** tb_ethernet_global_control_led.sv ***
// Self-checking testbench of the global control bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_ethernet_global_control_led;
  import egc_pkg::*;
  localparam logic [2:0] DEV = 3'h2; // Arbitrary value
  localparam logic [4:0] REV = 5'h0A; // Arbitrary value
  // ****************
  // Design and host
  // ****************
  logic clk, rst_n, reg_sel, reg_wr, reg_rd, reg_rvalid, reg_busy, ok, prev;
  logic device_enable_bit, power_down, source_address_insert, hash_algorithm_select, auto_pause_enable;
  logic transmit_reset, receive_reset, transmit_request_clear, receive_enable_clear, master_reset;
  logic led_output_one, led_output_two, reference_clock_output;
  logic [1:0] reg_be, modexp_length_select, cipher_key_length_select;
  logic [10:0] modexp_operand_bits;
  logic [8:0] cipher_key_bits;
  logic [5:0] st;
  logic [3:0] rst_vec;
  egc_word_t reg_wdata, reg_rdata, q;
  int error_cnt, total_checks;
  assign rst_vec = {transmit_reset, transmit_request_clear, receive_reset, receive_enable_clear};
  // Short stretch keeps the run small; expectations use the same figure
  egc_top #(.STRETCH_CYCLES(20), .DEVICE_ID(DEV), .REVISION(REV)) u_egc_top (.clk, .rst_n, .reg_sel,
    .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_busy, .link_up(st[5]),
    .speed_100(st[4]), .phy_duplex_flag(st[3]), .tx_active(st[2]), .rx_active(st[1]), .collision(st[0]),
    .device_enable_bit, .power_down, .source_address_insert, .hash_algorithm_select, .auto_pause_enable,
    .transmit_reset, .receive_reset, .transmit_request_clear, .receive_enable_clear, .master_reset,
    .modexp_length_select, .modexp_operand_bits, .cipher_key_length_select, .cipher_key_bits,
    .led_output_one, .led_output_two, .reference_clock_output);
  egc_host_model u_egc_host_model (.clk, .reg_rdata, .reg_rvalid, .reg_sel, .reg_wr, .reg_rd, .reg_be,
    .reg_wdata);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************
  // Scenarios
  // ****************
  function automatic logic led_exp(input logic [3:0] c, input logic two, input logic [5:0] s);
    logic l, sp, d, t, r, co;
    logic [15:0] v;
    {l, sp, d, t, r, co} = s;
    v = {l & !(t | r) & (two ? !sp : sp), l & !(t | r) & (two ? !d : d), 1'b0, l & !co, l & !(t | r),
         l & !r, l & !t, sp & l, d & l, t | r, r, t, co, l, 1'b1, 1'b0};
    return v[c];
  endfunction
  task automatic rd_chk(input logic sel, input egc_word_t e);
    u_egc_host_model.rd(sel, q, ok);
    `CHK(ok, 1'b1)
    `CHK(q, e)
  endtask
  task automatic t_ctrl_fields();
    logic [10:0] mx [4] = '{11'h200, 11'h300, 11'h400, 11'h000};
    logic [8:0] kx [4] = '{9'h080, 9'h0C0, 9'h100, 9'h000};
    rd_chk(1'b0, 16'hCB00);
    rd_chk(1'b1, {8'h26, DEV, REV});
    u_egc_host_model.wr(1'b0, 2'b10, 16'h3B00);
    `CHK({device_enable_bit, power_down, source_address_insert, hash_algorithm_select}, 4'h7)
    for (int i = 0; i < 4; i++) begin
      u_egc_host_model.wr(1'b0, 2'b01, {8'h00, 4'h8, i[1:0], i[1:0]});
      `CHK({modexp_length_select, cipher_key_length_select}, {i[1:0], i[1:0]})
      `CHK(modexp_operand_bits, mx[i])
      `CHK(cipher_key_bits, kx[i])
      `CHK(auto_pause_enable, 1'b1)
    end
    rd_chk(1'b0, 16'h3B8F);
    u_egc_host_model.wr(1'b0, 2'b11, 16'hCB40);
    `CHK({device_enable_bit, power_down, source_address_insert, hash_algorithm_select}, 4'h8)
    `CHK(rst_vec, 4'hC)
    u_egc_host_model.wr(1'b0, 2'b01, 16'h0020);
    `CHK(rst_vec, 4'h3)
    u_egc_host_model.wr(1'b1, 2'b11, 16'hFFFF);
    rd_chk(1'b1, {8'hFF, DEV, REV});
  endtask
  task automatic t_leds();
    logic [3:0] k;
    u_egc_host_model.wr(1'b0, 2'b11, 16'h8B00);
    for (int c = 0; c < 16; c++) begin
      k = c[3:0];
      u_egc_host_model.wr(1'b1, 2'b10, {k, k, 8'h00});
      for (int s = 0; s < 64; s++) begin
        st = s[5:0];
        @(negedge clk);
        `CHK({led_output_one, led_output_two}, {led_exp(k, 1'b0, st), led_exp(k, 1'b1, st)})
      end
    end
    st = 6'h00;
    // Stretched transmit and collision events, retriggered part way through
    u_egc_host_model.wr(1'b0, 2'b10, 16'hCB00);
    u_egc_host_model.wr(1'b1, 2'b10, 16'h4300);
    for (int i = 0; i < 2; i++) begin
      st = 6'h05;
      @(negedge clk);
      st = 6'h00;
      repeat (10) @(negedge clk);
    end
    repeat (8) @(negedge clk);
    `CHK({led_output_one, led_output_two}, 2'b11)
    repeat (6) @(negedge clk);
    `CHK({led_output_one, led_output_two}, 2'b00)
  endtask
  task automatic t_refclk();
    int p2 [16] = '{0, 6, 8, 10, 12, 16, 20, 24, 25, 32, 40, 50, 64, 0, 2000, 4000};
    int rises, cyc;
    for (int c = 0; c < 16; c++) begin
      u_egc_host_model.wr(1'b0, 2'b10, {4'hC, c[3:0], 8'h00});
      rises = 0;
      cyc = 0;
      prev = 1'b1;
      // Two whole periods from the second rise, so the switch-over period is ignored
      for (int k = 0; k < 8200 && rises < 4; k++) begin
        @(negedge clk);
        rises += int'(reference_clock_output === 1'b1 && !prev);
        prev = reference_clock_output;
        cyc += int'(rises > 1);
      end
      `CHK(cyc, (p2[c] == 0) ? 0 : p2[c] + 1)
    end
  endtask
  task automatic t_master_reset();
    int n;
    u_egc_host_model.wr(1'b0, 2'b11, 16'h3780);
    u_egc_host_model.wr_raw(1'b0, 2'b01, 16'h0010);
    u_egc_host_model.wr_raw(1'b1, 2'b11, 16'h0000);
    `CHK({reg_busy, master_reset, rst_vec[3], rst_vec[1]}, 4'hF)
    u_egc_host_model.rd(1'b0, q, ok);
    `CHK(ok, 1'b0)
    for (n = 4; n < 700 && reg_busy === 1'b1; n++) @(negedge clk);
    `CHK(n, 625)
    rd_chk(1'b0, 16'hC700);
    rd_chk(1'b1, {8'h26, DEV, REV});
    // Host-side wait must cover the whole refusal time
    u_egc_host_model.wr(1'b0, 2'b01, 16'h0010);
    rd_chk(1'b0, 16'hC700);
    // Only a power-on reset brings the divider field back
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(1'b0, 16'hCB00);
  endtask
  task automatic t_host_setup();
    u_egc_host_model.link_setup(1'b0, 24);
    `CHK(u_egc_host_model.nonconsecutive_gap_low_byte, 7'h12)
    `CHK(u_egc_host_model.mac_full_duplex_bit, 1'b0)
    `CHK(u_egc_host_model.consecutive_gap_register, 7'h12)
    u_egc_host_model.link_setup(1'b1, 24);
    `CHK(u_egc_host_model.mac_full_duplex_bit, 1'b1)
    `CHK(u_egc_host_model.consecutive_gap_register, 7'h15)
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    st = 6'h00;
    error_cnt = 0;
    total_checks = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_ctrl_fields();
    t_leds();
    t_refclk();
    t_master_reset();
    t_host_setup();
    test_done();
  end
endmodule
